// ---- core/ebt_pkg.sv ----
/*
  Constants shared by the eight-bit timer block: register indices,
  control field positions, reset values and bus codes.
  Assumes an AHB-Lite bus with 32-bit data, one register per word.
*/
package ebt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTRL = 12'hD00;
  localparam logic [11:0] IDX_LOW_PHASE = 12'hD04;
  localparam logic [11:0] IDX_HIGH_PHASE = 12'hD05;
  localparam logic [11:0] IDX_WIDE_LOW = 12'hD06;
  localparam logic [11:0] IDX_WIDE_HIGH = 12'hD07;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'hD10;
  localparam logic [11:0] IDX_IRQ_MASK = 12'hD11;

  // Index field of the byte address
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 13;

  // Control register fields
  localparam int CTL_RUN = 7;
  localparam int CTL_SINGLE = 6;
  localparam int CTL_TIMEOUT = 5;
  localparam int CTL_PRE_MSB = 4;
  localparam int CTL_PRE_LSB = 3;
  localparam int CTL_CAP_IE = 2;
  localparam int CTL_TC_IE = 1;
  localparam int CTL_PIN_SEL = 0;

  // Interrupt status and mask fields
  localparam int IRQ_TC = 0;
  localparam int IRQ_CAP = 1;
  localparam int IRQ_W = 2;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] HOLD_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // Control bits kept through a stop-mode recovery
  localparam logic [7:0] CTRL_RECOVER_KEEP = 8'h3E;

  // Prescale selections
  localparam logic [1:0] PRE_DIV8 = 2'h3;

  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : ebt_pkg

// ---- core/ebt_prescale.sv ----
/*
  Prescaler for the eight-bit timer: one-cycle tick enable at the
  system clock divided by 1, 2, 4 or 8.
  Assumes one clock; clr restarts the division at timer start.
*/
`timescale 1ns/100ps
module ebt_prescale #(
  parameter int DIV_W = 3
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick
);
  import ebt_pkg::*;

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] mask_w;

  // Low sel bits of the counter must all be ones to tick
  assign mask_w = ~({DIV_W{1'b1}} << sel);
  assign tick = run & ((cnt_q & mask_w) == mask_w);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clr) begin
      cnt_q <= '0;
    end else if (run) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule : ebt_prescale

// ---- core/ebt_timer.sv ----
/*
  Eight-bit timer with its control register, phase count holds and
  the reload byte holds of the wide timer, reached over AHB-Lite.
  Assumes single-clock surroundings; stop_recover, capture_event,
  init_level and port_out_value come from logic on the same clock.
*/
`timescale 1ns/100ps
// Behaviour
// - Low reload byte feeds wide timer low
// - High-phase count used while output high
// - Low-phase count used while output low
// - Hold registers survive stop-mode recovery
// - Time-out flag clears only by writing one
// - Bit 7 runs or stops the counter
// - Bit 6 picks reload or stop
// - Bit 5 set by terminal count
// - Bits 4:3 select tick divide 1-8
// - Prescale and interrupt enables survive recovery
// - Bit 2 enables capture interrupt
// - Bit 1 enables terminal count interrupt
// - Bit 0 routes timer output to pin
// - Load phase count by output level
// - High reload byte feeds wide timer high
module ebt_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic stop_recover,
  input wire logic capture_event,
  input wire logic init_level,
  input wire logic port_out_value,
  output logic eight_bit_timer_output,
  output logic port3_pin4,
  output logic [15:0] wide_timer_reload,
  output logic irq
);
  import ebt_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] low_q;
  logic [7:0] high_q;
  logic [7:0] wlow_q;
  logic [7:0] whigh_q;
  logic [IRQ_W-1:0] imask_q;
  logic [IRQ_W-1:0] istat_q;
  logic [IRQ_W-1:0] istat_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic out_q;
  logic out_d;
  logic run_prev_q;
  logic pin_q;
  logic [15:0] reload_q;

  // Bus data phase state
  logic dph_q;
  logic dwr_q;
  logic [11:0] didx_q;

  logic addr_ok_w;
  logic take_w;
  logic wr_w;
  logic [7:0] wd_w;
  logic wr_ctrl_w;
  logic wr_low_w;
  logic wr_high_w;
  logic wr_wlow_w;
  logic wr_whigh_w;
  logic wr_istat_w;
  logic wr_imask_w;
  logic [7:0] rd_byte_w;

  logic run_w;
  logic start_w;
  logic tick_w;
  logic tc_w;
  logic [7:0] phase_val_w;
  logic [IRQ_W-1:0] irq_set_w;

  // Address phase decode
  assign addr_ok_w = (haddr[31:ADDR_IDX_MSB+1] == '0);
  assign take_w = hsel & hready & htrans[1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dph_q <= 1'b0;
      dwr_q <= 1'b0;
      didx_q <= '0;
    end else if (hready) begin
      dph_q <= take_w & addr_ok_w;
      dwr_q <= hwrite;
      didx_q <= haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
    end
  end

  // Data phase write strobes
  assign wr_w = dph_q & dwr_q;
  assign wd_w = hwdata[7:0];
  assign wr_ctrl_w = wr_w & (didx_q == IDX_CTRL);
  assign wr_low_w = wr_w & (didx_q == IDX_LOW_PHASE);
  assign wr_high_w = wr_w & (didx_q == IDX_HIGH_PHASE);
  assign wr_wlow_w = wr_w & (didx_q == IDX_WIDE_LOW);
  assign wr_whigh_w = wr_w & (didx_q == IDX_WIDE_HIGH);
  assign wr_istat_w = wr_w & (didx_q == IDX_IRQ_STATUS);
  assign wr_imask_w = wr_w & (didx_q == IDX_IRQ_MASK);

  // Read mux; unmapped words read zero
  assign rd_byte_w = !dph_q ? 8'h00 :
                     (didx_q == IDX_CTRL) ? ctrl_q :
                     (didx_q == IDX_LOW_PHASE) ? low_q :
                     (didx_q == IDX_HIGH_PHASE) ? high_q :
                     (didx_q == IDX_WIDE_LOW) ? wlow_q :
                     (didx_q == IDX_WIDE_HIGH) ? whigh_q :
                     (didx_q == IDX_IRQ_STATUS) ? {6'h00, istat_q} :
                     (didx_q == IDX_IRQ_MASK) ? {6'h00, imask_q} : 8'h00;
  assign hrdata = {24'h000000, rd_byte_w};
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

  // Timer sequencing
  assign run_w = ctrl_q[CTL_RUN];
  assign start_w = run_w & ~run_prev_q;

  ebt_prescale #(
    .DIV_W(3)
  ) u_prescale (
    .clock(clock),
    .rst_n(rst_n),
    .clr(start_w),
    .run(run_w),
    .sel(ctrl_q[CTL_PRE_MSB:CTL_PRE_LSB]),
    .tick(tick_w)
  );

  assign tc_w = run_w & ~start_w & tick_w & (cnt_q <= 8'h01);

  // Pick phase count from next level
  assign phase_val_w = out_d ? high_q : low_q;

  always_comb begin
    out_d = out_q;
    cnt_d = cnt_q;
    if (start_w) begin
      out_d = init_level;
      cnt_d = phase_val_w;
    end else if (tc_w) begin
      out_d = ~out_q;
      cnt_d = ctrl_q[CTL_SINGLE] ? 8'h00 : phase_val_w;
    end else if (run_w && tick_w) begin
      cnt_d = cnt_q - 8'h01;
    end
  end

  // Control register next value
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl_w) begin
      ctrl_d = wd_w;
      // Writing one clears, zero leaves it
      ctrl_d[CTL_TIMEOUT] = ctrl_q[CTL_TIMEOUT] & ~wd_w[CTL_TIMEOUT];
    end else if (tc_w && ctrl_q[CTL_SINGLE]) begin
      ctrl_d[CTL_RUN] = 1'b0;
    end
    // Terminal count sets flag, set wins
    if (tc_w) begin
      ctrl_d[CTL_TIMEOUT] = 1'b1;
    end
    if (stop_recover) begin
      ctrl_d = ctrl_d & CTRL_RECOVER_KEEP;
    end
  end

  assign irq_set_w[IRQ_TC] = tc_w & ctrl_q[CTL_TC_IE];
  assign irq_set_w[IRQ_CAP] = capture_event & ctrl_q[CTL_CAP_IE];

  always_comb begin
    istat_d = istat_q;
    if (wr_istat_w) begin
      istat_d = istat_q & ~wd_w[IRQ_W-1:0];
    end
    istat_d = istat_d | irq_set_w;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      istat_q <= IRQ_RESET;
      run_prev_q <= 1'b0;
      cnt_q <= 8'h00;
      out_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      istat_q <= istat_d;
      run_prev_q <= run_w;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= HOLD_RESET;
      high_q <= HOLD_RESET;
      wlow_q <= HOLD_RESET;
      whigh_q <= HOLD_RESET;
      imask_q <= IRQ_RESET;
    end else begin
      if (wr_high_w) high_q <= wd_w;
      if (wr_low_w) low_q <= wd_w;
      if (wr_wlow_w) wlow_q <= wd_w;
      if (wr_whigh_w) whigh_q <= wd_w;
      if (wr_imask_w) imask_q <= wd_w[IRQ_W-1:0];
    end
  end

  // Registered pin and reload outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
      reload_q <= 16'h0000;
    end else begin
      // Pin takes timer or port value
      pin_q <= ctrl_q[CTL_PIN_SEL] ? out_q : port_out_value;
      reload_q[7:0] <= wlow_q;
      reload_q[15:8] <= whigh_q;
    end
  end

  assign eight_bit_timer_output = out_q;
  assign port3_pin4 = pin_q;
  assign wide_timer_reload = reload_q;
  assign irq = |(istat_q & imask_q);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_wide_low;
    $changed(wlow_q) |=> wide_timer_reload[7:0] == $past(wlow_q);
  endproperty
  a_wide_low: assert property (p_wide_low)
    else $error("wide reload low byte not passed on");

  property p_wide_high;
    $changed(whigh_q) |=> wide_timer_reload[15:8] == $past(whigh_q);
  endproperty
  a_wide_high: assert property (p_wide_high)
    else $error("wide reload high byte not passed on");

  property p_high_load;
    start_w && init_level |=> out_q && cnt_q == $past(high_q);
  endproperty
  a_high_load: assert property (p_high_load)
    else $error("high phase did not load high count");

  property p_low_load;
    start_w && !init_level |=> !out_q && cnt_q == $past(low_q);
  endproperty
  a_low_load: assert property (p_low_load)
    else $error("low phase did not load low count");

  property p_phase_reload;
    tc_w && !ctrl_q[CTL_SINGLE] |=> cnt_q == (out_q ? $past(high_q) : $past(low_q));
  endproperty
  a_phase_reload: assert property (p_phase_reload)
    else $error("reload did not follow output level");

  property p_hold_keep;
    stop_recover && !wr_w |=> $stable(low_q) && $stable(high_q) && $stable(wlow_q);
  endproperty
  a_hold_keep: assert property (p_hold_keep)
    else $error("hold register changed on recovery");

  property p_flag_clear;
    $fell(ctrl_q[CTL_TIMEOUT]) |-> $past(wr_ctrl_w && wd_w[CTL_TIMEOUT]);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("time-out flag cleared without write of one");

  property p_flag_set;
    tc_w |=> ctrl_q[CTL_TIMEOUT];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("terminal count did not set flag");

  property p_single_stop;
    tc_w && ctrl_q[CTL_SINGLE] && !wr_ctrl_w |=> !ctrl_q[CTL_RUN];
  endproperty
  a_single_stop: assert property (p_single_stop)
    else $error("single pass did not stop");

  property p_div8;
    tick_w && run_w && ctrl_q[CTL_PRE_MSB:CTL_PRE_LSB] == PRE_DIV8 && !wr_ctrl_w
      |=> !tick_w [*7];
  endproperty
  a_div8: assert property (p_div8)
    else $error("divide by eight ticked early");

  property p_stopped;
    !run_w && !run_prev_q |=> $stable(cnt_q) && $stable(out_q);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved while stopped");

  property p_decrement;
    run_w && tick_w && !start_w && !tc_w |=> cnt_q == $past(cnt_q) - 8'h01;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("count did not decrement on tick");

  property p_recover_keep;
    stop_recover && !wr_ctrl_w |=> ctrl_q[4:1] == $past(ctrl_q[4:1]) && !ctrl_q[CTL_RUN];
  endproperty
  a_recover_keep: assert property (p_recover_keep)
    else $error("recovery lost kept control bits");

  property p_cap_irq;
    capture_event && ctrl_q[CTL_CAP_IE] && imask_q[IRQ_CAP] |=> istat_q[IRQ_CAP] && irq;
  endproperty
  a_cap_irq: assert property (p_cap_irq)
    else $error("capture interrupt missing");

  property p_tc_irq;
    tc_w && ctrl_q[CTL_TC_IE] && imask_q[IRQ_TC] |=> irq;
  endproperty
  a_tc_irq: assert property (p_tc_irq)
    else $error("terminal count interrupt missing");

  property p_tc_quiet;
    !ctrl_q[CTL_TC_IE] && !istat_q[IRQ_TC] |=> !istat_q[IRQ_TC];
  endproperty
  a_tc_quiet: assert property (p_tc_quiet)
    else $error("disabled terminal count raised status");

  property p_pin;
    ctrl_q[CTL_PIN_SEL] |=> port3_pin4 == $past(out_q);
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin does not carry timer output");

endmodule : ebt_timer

// ---- verif/eight_bit_timer_control_and_reload_tb.sv ----
/*
  Self-checking bench for the eight-bit timer block: AHB-Lite master
  tasks, an integer register model and phase timing measurements.
  Assumes ebt_pkg and ebt_timer are compiled first.
*/
`timescale 1ns/100ps
module eight_bit_timer_control_and_reload_tb;
  import ebt_pkg::*;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic stop_recover = 1'h0;
  logic capture_event = 1'h0;
  logic init_level = 1'h1;
  logic port_out_value = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = HTRANS_IDLE;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, t_out, pin, irq;
  logic [31:0] hrdata;
  logic [15:0] wide;
  logic [11:0] regs [8] = '{IDX_CTRL, IDX_LOW_PHASE, IDX_HIGH_PHASE, IDX_WIDE_LOW,
    IDX_WIDE_HIGH, IDX_IRQ_STATUS, IDX_IRQ_MASK, 12'hD20};
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 54;
  int n;
  int mdl [4096];

  assign hready = hreadyout;
  always #5 clock = ~clock;

  ebt_timer i_ebt_timer (
    .clock(clock),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .stop_recover(stop_recover),
    .capture_event(capture_event),
    .init_level(init_level),
    .port_out_value(port_out_value),
    .eight_bit_timer_output(t_out),
    .port3_pin4(pin),
    .wide_timer_reload(wide),
    .irq(irq)
  );

  task automatic tally_and_finish;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task automatic hang;
    mismatches++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    tally_and_finish();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Waits for a rising edge where hready is sampled high
  task automatic edge_ready;
    int k;
    k = 0;
    @(posedge clock);
    while (hreadyout !== 1'h1) begin
      k++;
      if (k > 50) hang();
      @(posedge clock);
    end
  endtask : edge_ready

  task automatic bus(input logic [11:0] idx, input logic w, input logic [7:0] d,
                     output logic [31:0] r);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, idx, 2'h0};
    edge_ready();
    hsel <= 1'h0;
    htrans <= HTRANS_IDLE;
    hwdata <= {24'h0, d};
    edge_ready();
    r = hrdata;
    chk(hresp, HRESP_OKAY);
  endtask : bus

  // Write with the model following flag and mask semantics
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(idx, 1'h1, d, r);
    if (idx == IDX_CTRL) begin
      mdl[idx] = {d[7:6], mdl[idx][5] & ~d[5], d[4:0]};
    end else if (idx == IDX_IRQ_STATUS) begin
      mdl[idx] = mdl[idx][1:0] & ~d[1:0];
    end else if (idx inside {IDX_LOW_PHASE, IDX_HIGH_PHASE, IDX_WIDE_LOW,
                             IDX_WIDE_HIGH, IDX_IRQ_MASK}) begin
      mdl[idx] = d;
    end
  endtask : wr

  task automatic rd(input logic [11:0] idx);
    logic [31:0] r;
    bus(idx, 1'h0, 8'h0, r);
    chk(r, 32'(mdl[idx]));
  endtask : rd

  // Cycles until the timer output changes level
  task automatic tog(output int c);
    logic v;
    v = t_out;
    c = 0;
    do begin
      @(posedge clock);
      c++;
      if (c > 300) hang();
    end while (t_out === v);
  endtask : tog

  task automatic pulse(input logic recover);
    if (recover) begin
      stop_recover <= 1'h1;
    end else begin
      capture_event <= 1'h1;
    end
    @(posedge clock);
    stop_recover <= 1'h0;
    capture_event <= 1'h0;
    repeat (2) @(posedge clock);
  endtask : pulse

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    for (int i = 0; i < 8; i++) rd(regs[i]);
    repeat (4) begin
      for (int i = 1; i < 5; i++) wr(regs[i], 8'($random(seed)));
      wr(12'hD20, 8'hA5);
      for (int i = 1; i < 8; i++) rd(regs[i]);
      chk(wide, {mdl[IDX_WIDE_HIGH][7:0], mdl[IDX_WIDE_LOW][7:0]});
    end
    wr(IDX_LOW_PHASE, 8'h02);
    wr(IDX_HIGH_PHASE, 8'h03);
    wr(IDX_IRQ_MASK, 8'h01);
    for (int p = 0; p < 4; p++) begin
      // Random start level exercises both phase loads
      init_level <= 1'($random(seed));
      wr(IDX_CTRL, 8'h20);
      wr(IDX_CTRL, 8'h82 | 8'(p << 3));
      repeat (2) tog(n);
      repeat (2) begin
        tog(n);
        chk(32'(n), 32'((t_out ? 2 : 3) << p));
      end
      mdl[IDX_CTRL][5] = 1'h1;
      mdl[IDX_IRQ_STATUS][0] = 1'h1;
      rd(IDX_CTRL);
      rd(IDX_IRQ_STATUS);
      chk(irq, 1'h1);
      wr(IDX_CTRL, 8'h00);
      rd(IDX_CTRL);
      wr(IDX_IRQ_STATUS, 8'h01);
      // Status clears at the closing edge; look one cycle on
      @(posedge clock);
      chk(irq, 1'h0);
    end
    init_level <= 1'h0;
    wr(IDX_LOW_PHASE, 8'h01);
    wr(IDX_HIGH_PHASE, 8'h01);
    wr(IDX_CTRL, 8'h20);
    wr(IDX_CTRL, 8'hC1);
    repeat (20) @(posedge clock);
    mdl[IDX_CTRL] = 32'h61;
    rd(IDX_CTRL);
    n = t_out;
    repeat (20) @(posedge clock);
    chk(t_out, n[0]);
    chk(t_out, 1'h1);
    chk(pin, t_out);
    wr(IDX_CTRL, 8'h40);
    repeat (4) begin
      port_out_value <= 1'($random(seed));
      repeat (3) @(posedge clock);
      chk(pin, port_out_value);
    end
    wr(IDX_CTRL, 8'h04);
    wr(IDX_IRQ_MASK, 8'h00);
    pulse(1'h0);
    mdl[IDX_IRQ_STATUS][1] = 1'h1;
    rd(IDX_IRQ_STATUS);
    chk(irq, 1'h0);
    wr(IDX_IRQ_MASK, 8'h02);
    @(posedge clock);
    chk(irq, 1'h1);
    wr(IDX_IRQ_STATUS, 8'h02);
    @(posedge clock);
    chk(irq, 1'h0);
    wr(IDX_CTRL, 8'h00);
    pulse(1'h0);
    rd(IDX_IRQ_STATUS);
    for (int i = 1; i < 5; i++) wr(regs[i], 8'($random(seed)));
    wr(IDX_CTRL, 8'h5F);
    pulse(1'h1);
    mdl[IDX_CTRL] = mdl[IDX_CTRL] & 32'(CTRL_RECOVER_KEEP);
    for (int i = 0; i < 7; i++) rd(regs[i]);
    rst_n <= 1'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    foreach (mdl[i]) mdl[i] = 0;
    for (int i = 0; i < 8; i++) rd(regs[i]);
    tally_and_finish();
  end
endmodule : eight_bit_timer_control_and_reload_tb
